// ### rtl/clock_switch_defs.svh
// offsets, field positions, reset values and timing counts of the clock switcher
`ifndef CLOCK_SWITCH_DEFS_SVH
`define CLOCK_SWITCH_DEFS_SVH
// register word indices, taken from byte address bits 5:2 on the control bus
`define OFS_MODE 4'h0
`define OFS_DIV 4'h1
`define OFS_MAINOSC 4'h2
`define OFS_LOWOSC 4'h3
`define OFS_STAB 4'h4
`define OFS_STABSEL 4'h5
`define ADDR_LSB 2
`define ADDR_MSB 5
// field positions
`define MODE_SEL_BIT 0
`define MODE_STAT_BIT 1
`define MAIN_STOP_BIT 7
`define LOW_STOP_BIT 0
`define DIV_MSB 2
`define STABSEL_MSB 2
`define FLAGS_MSB 3
// reset values
`define SEL_RST 1'b0
`define STAT_RST 1'b0
`define DIV_RST 3'h0
`define STOP_RST 1'b0
`define STABSEL_RST 3'h4
// divider codes and switching counts
`define DIV_SLOWEST 3'h4
`define TO_HIGH_CLKS 2'h2
// stabilization counter, thresholds as counter bit indices
`define STAB_W 16
`define STAB_B11 11
`define STAB_B13 13
`define STAB_B14 14
`define STAB_B15 15
// bus answers
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ### rtl/clock_switch_pkg.sv
// types shared by the clock switcher modules
package clock_switch_pkg;
   typedef enum logic [1:0] {MuxSteady, MuxToHigh, MuxToLowCpu, MuxToLowEdge} mux_state_t;
endpackage : clock_switch_pkg

// ### rtl/cpu_clock_prescaler.sv
// divides the selected source ticks into cpu ticks; ratio changes only at a boundary
`timescale 1ns/100ps
`include "clock_switch_defs.svh"
module cpu_clock_prescaler (
   input wire logic clock,
   input wire logic reset,
   input wire logic srcTick,
   input wire logic restart,
   input wire logic [2:0] divReq,
   output logic cpuTick,
   output logic [2:0] divActive
);
   logic [3:0] phase_r, phase_nxt;
   logic [2:0] div_r, div_nxt;
   logic [2:0] divEff;
   logic [3:0] mask;

   // codes above the slowest one behave as the slowest
   always_comb begin
      divEff = (div_r > `DIV_SLOWEST) ? `DIV_SLOWEST : div_r;
      mask = 4'((5'h01 << divEff) - 5'h01);
      cpuTick = srcTick && ((phase_r & mask) == mask);
   end

   // a new ratio is taken when the slowest period wraps: at most 16/8/4/2/1 old clocks
   always_comb begin
      phase_nxt = phase_r;
      div_nxt = div_r;
      if (restart) begin
         phase_nxt = 4'h0;
         div_nxt = divReq;
      end else if (srcTick) begin
         phase_nxt = phase_r + 4'h1;
         if (phase_r == 4'hf) begin
            div_nxt = divReq;
         end
      end
      divActive = div_r;
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         phase_r <= 4'h0;
         div_r <= `DIV_RST;
      end else begin
         phase_r <= phase_nxt;
         div_r <= div_nxt;
      end
   end
endmodule : cpu_clock_prescaler

// ### rtl/clock_source_mux.sv
// glitch-free hand-over between low-speed and high-speed source ticks
`timescale 1ns/100ps
`include "clock_switch_defs.svh"
module clock_source_mux (
   input wire logic clock,
   input wire logic reset,
   input wire logic sourceSelect,
   input wire logic cpuTick,
   input wire logic highTick,
   input wire logic lowTick,
   output logic srcTick,
   output logic handOver,
   output logic sourceStatus
);
   clock_switch_pkg::mux_state_t state_r, state_nxt;
   logic status_r, status_nxt;
   logic [1:0] count_r, count_nxt;

   // the status flop is the mux select itself, so it flips at the hand-over edge
   assign srcTick = status_r ? highTick : lowTick;
   assign sourceStatus = status_r;

   always_comb begin
      state_nxt = state_r;
      status_nxt = status_r;
      count_nxt = count_r;
      handOver = 1'b0;
      case (state_r)
         clock_switch_pkg::MuxSteady: begin
            count_nxt = 2'h0;
            if (sourceSelect && !status_r) begin
               state_nxt = clock_switch_pkg::MuxToHigh;
            end else if (!sourceSelect && status_r) begin
               state_nxt = clock_switch_pkg::MuxToLowCpu;
            end
         end
         // low to high: two old cpu clocks, then swap
         clock_switch_pkg::MuxToHigh: begin
            if (cpuTick) begin
               count_nxt = count_r + 2'h1;
               if (count_r + 2'h1 == `TO_HIGH_CLKS) begin
                  status_nxt = 1'b1;
                  handOver = 1'b1;
                  state_nxt = clock_switch_pkg::MuxSteady;
               end
            end
         end
         // high to low: finish the running cpu clock, then wait for a low edge;
         // worst case is one low period plus one old clock
         clock_switch_pkg::MuxToLowCpu: begin
            if (cpuTick) begin
               state_nxt = clock_switch_pkg::MuxToLowEdge;
            end
         end
         clock_switch_pkg::MuxToLowEdge: begin
            if (lowTick) begin
               status_nxt = 1'b0;
               handOver = 1'b1;
               state_nxt = clock_switch_pkg::MuxSteady;
            end
         end
         default: begin
            state_nxt = clock_switch_pkg::MuxSteady;
         end
      endcase
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         state_r <= clock_switch_pkg::MuxSteady;
         status_r <= `STAT_RST;
         count_r <= 2'h0;
      end else begin
         state_r <= state_nxt;
         status_r <= status_nxt;
         count_r <= count_nxt;
      end
   end
endmodule : clock_source_mux

// ### rtl/cpu_clock_source_switcher.sv
// cpu clock source switcher: registers, oscillator control, stabilization and switching
// Function
// - select bit 0 of mode register picks low-speed (0) or high-speed (1) source.
// - after select is rewritten the old source runs on for a while.
// - read-only status bit 1 shows which source really clocks the cpu.
// - high-to-low within one low period plus one old clock; low-to-high takes two clocks.
// - divider bits 0..2 pick the cpu ratio; new ratio applies after a delay.
// - divider switchover at most 16, 8, 4, 2, 1 old clocks by old setting.
// - stabilization wait applies only to interrupt release from STOP on high-speed.
// - low oscillator stop bit acts only when the option makes it stoppable.
// - main stop bit cannot stop the main oscillator while it clocks the cpu.
// - low stop bit cannot stop the low oscillator while it clocks the cpu.
// - valid flag combinations per operating mode are software's duty; hardware only keeps the oscillator in use running.
// - main stop is bit 7 of its register; low stop is bit 0.
`timescale 1ns/100ps
`include "clock_switch_defs.svh"
module cpu_clock_source_switcher (
   input wire logic clock,
   input wire logic reset,
   // axi4-lite slave
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // oscillator ticks, one cycle per oscillator period
   input wire logic highTick,
   input wire logic lowTick,
   // option byte: low-speed oscillator may be stopped by software
   input wire logic lowOscStoppable,
   // cpu power state
   input wire logic stopMode,
   input wire logic wakeByIrq,
   // outputs
   output logic cpuTick,
   output logic cpuOnHigh,
   output logic mainOscEnable,
   output logic lowOscEnable,
   output logic [2:0] cpuDivActive
);
   ////////////////////////////////////////////////////////////////////////////
   // register state
   // control fields written by software, then the stabilization counter and hold
   logic sel_r, sel_nxt;
   logic [2:0] div_r, div_nxt;
   logic mainStop_r, mainStop_nxt;
   logic lowStop_r, lowStop_nxt;
   logic [2:0] stabSel_r, stabSel_nxt;
   logic [`STAB_W-1:0] stab_r, stab_nxt;
   logic stabHold_r, stabHold_nxt;

   // bus side state: one write and one read in flight at most
   logic awHeld_r, awHeld_nxt;
   logic wHeld_r, wHeld_nxt;
   logic [31:0] awAddr_r, awAddr_nxt;
   logic [31:0] wData_r, wData_nxt;
   logic [3:0] wStrb_r, wStrb_nxt;
   logic bValid_r, bValid_nxt;
   logic [1:0] bResp_r, bResp_nxt;
   logic rValid_r, rValid_nxt;
   logic [1:0] rResp_r, rResp_nxt;
   logic [31:0] rData_r, rData_nxt;

   // nets between the sub-blocks and the bus logic
   logic sourceStatus;
   logic srcTick;
   logic rawCpuTick;
   logic handOver;
   logic stabReached;
   logic [3:0] stabFlags;
   logic [3:0] wIdx;
   logic [3:0] rIdx;

   ////////////////////////////////////////////////////////////////////////////
   // source mux and prescaler
   // the mux owns the status bit, and the prescaler restarts its phase at each hand-over
   clock_source_mux mux (
      .clock(clock),
      .reset(reset),
      .sourceSelect(sel_r),
      .cpuTick(rawCpuTick),
      .highTick(highTick),
      .lowTick(lowTick),
      .srcTick(srcTick),
      .handOver(handOver),
      .sourceStatus(sourceStatus)
   );

   // the divider register feeds the prescaler at once; the prescaler applies it at its wrap
   cpu_clock_prescaler prescaler (
      .clock(clock),
      .reset(reset),
      .srcTick(srcTick),
      .restart(handOver),
      .divReq(div_r),
      .cpuTick(rawCpuTick),
      .divActive(cpuDivActive)
   );

   ////////////////////////////////////////////////////////////////////////////
   // oscillator enables: a stop bit never stops the oscillator in use;
   // prohibited stop and divider combinations stay software's duty and are not blocked
   always_comb begin
      mainOscEnable = !(mainStop_r && !sourceStatus);
      lowOscEnable = !(lowOscStoppable && lowStop_r && sourceStatus);
      cpuOnHigh = sourceStatus;
      // the cpu is frozen in STOP and during the stabilization hold;
      // only the cpu loses these ticks, the prescaler and the mux keep counting raw ones
      cpuTick = rawCpuTick && !stopMode && !stabHold_r;
   end

   ////////////////////////////////////////////////////////////////////////////
   // stabilization counter: runs on main ticks, restarts whenever the osc stops
   always_comb begin
      // a threshold counts as reached once any bit at or above it is set; the counter
      // saturates at its top bit, so the flags fall back only when the oscillator stops or an interrupt wake restarts the count
      stabFlags[0] = |stab_r[`STAB_B15:`STAB_B11];
      stabFlags[1] = |stab_r[`STAB_B15:`STAB_B13];
      stabFlags[2] = |stab_r[`STAB_B15:`STAB_B14];
      stabFlags[3] = stab_r[`STAB_B15];
      case (stabSel_r)
         3'h0: stabReached = stabFlags[0];
         3'h1: stabReached = stabFlags[1];
         3'h2: stabReached = stabFlags[2];
         default: stabReached = stabFlags[3];
      endcase
      stab_nxt = stab_r;
      stabHold_nxt = stabHold_r;
      if (!mainOscEnable) begin
         stab_nxt = '0;
      end else if (wakeByIrq && stopMode && sourceStatus) begin
         stab_nxt = '0;
         stabHold_nxt = 1'b1;
      // the count stops at its top bit instead of wrapping
      end else if (highTick && !stab_r[`STAB_B15]) begin
         stab_nxt = stab_r + `STAB_W'(1);
      end
      // only the interrupt wake on the high clock waits; reset release never does
      // the hold drops one edge after the threshold, then the next selected tick runs
      if (stabHold_r && stabReached) begin
         stabHold_nxt = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // axi write path: address and data taken in either order, one write at a time
   always_comb begin
      // each ready drops while its own half is held; both drop while the answer stands
      s_axi_awready = !awHeld_r && !bValid_r;
      s_axi_wready = !wHeld_r && !bValid_r;
      awHeld_nxt = awHeld_r;
      wHeld_nxt = wHeld_r;
      awAddr_nxt = awAddr_r;
      wData_nxt = wData_r;
      wStrb_nxt = wStrb_r;
      bValid_nxt = bValid_r;
      bResp_nxt = bResp_r;
      sel_nxt = sel_r;
      div_nxt = div_r;
      mainStop_nxt = mainStop_r;
      lowStop_nxt = lowStop_r;
      stabSel_nxt = stabSel_r;
      wIdx = awAddr_r[`ADDR_MSB:`ADDR_LSB];
      if (s_axi_awvalid && s_axi_awready) begin
         awHeld_nxt = 1'b1;
         awAddr_nxt = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         wHeld_nxt = 1'b1;
         wData_nxt = s_axi_wdata;
         wStrb_nxt = s_axi_wstrb;
      end
      // commit one cycle after both halves are held; the new field is seen by the mux
      // and the prescaler from the next edge on
      if (awHeld_r && wHeld_r) begin
         awHeld_nxt = 1'b0;
         wHeld_nxt = 1'b0;
         bValid_nxt = 1'b1;
         bResp_nxt = `RESP_OKAY;
         // an address beyond the block answers with an error and changes nothing
         if (awAddr_r[31:`ADDR_MSB+1] != '0) begin
            bResp_nxt = `RESP_SLVERR;
         // every field sits in byte lane 0; a write without that lane changes nothing
         end else if (wStrb_r[0]) begin
            case (wIdx)
               `OFS_MODE: sel_nxt = wData_r[`MODE_SEL_BIT];
               `OFS_DIV: div_nxt = wData_r[`DIV_MSB:0];
               `OFS_MAINOSC: mainStop_nxt = wData_r[`MAIN_STOP_BIT];
               `OFS_LOWOSC: lowStop_nxt = wData_r[`LOW_STOP_BIT];
               `OFS_STABSEL: stabSel_nxt = wData_r[`STABSEL_MSB:0];
               `OFS_STAB: bResp_nxt = `RESP_OKAY; // read-only, write ignored
               default: bResp_nxt = `RESP_SLVERR;
            endcase
         end else if (wIdx > `OFS_STABSEL) begin
            bResp_nxt = `RESP_SLVERR;
         end
      end
      // the response stands until the master takes it, and no new write is taken meanwhile
      if (bValid_r && s_axi_bready) begin
         bValid_nxt = 1'b0;
      end
      s_axi_bvalid = bValid_r;
      s_axi_bresp = bResp_r;
   end

   ////////////////////////////////////////////////////////////////////////////
   // axi read path: data registered, answer one cycle after the address is taken
   always_comb begin
      s_axi_arready = !rValid_r;
      rValid_nxt = rValid_r;
      rResp_nxt = rResp_r;
      rData_nxt = rData_r;
      rIdx = s_axi_araddr[`ADDR_MSB:`ADDR_LSB];
      if (s_axi_arvalid && s_axi_arready) begin
         rValid_nxt = 1'b1;
         rResp_nxt = `RESP_OKAY;
         rData_nxt = 32'h0;
         if (s_axi_araddr[31:`ADDR_MSB+1] != '0) begin
            rResp_nxt = `RESP_SLVERR;
         end else begin
            // bits that hold no field read as zero
            case (rIdx)
               `OFS_MODE: begin
                  rData_nxt[`MODE_SEL_BIT] = sel_r;
                  rData_nxt[`MODE_STAT_BIT] = sourceStatus;
               end
               `OFS_DIV: rData_nxt[`DIV_MSB:0] = div_r;
               `OFS_MAINOSC: rData_nxt[`MAIN_STOP_BIT] = mainStop_r;
               `OFS_LOWOSC: rData_nxt[`LOW_STOP_BIT] = lowStop_r;
               `OFS_STAB: rData_nxt[`FLAGS_MSB:0] = stabFlags;
               `OFS_STABSEL: rData_nxt[`STABSEL_MSB:0] = stabSel_r;
               default: rResp_nxt = `RESP_SLVERR;
            endcase
         end
      // arready stays low while the answer stands, so one read at most is open
      end else if (rValid_r && s_axi_rready) begin
         rValid_nxt = 1'b0;
      end
      s_axi_rvalid = rValid_r;
      s_axi_rresp = rResp_r;
      s_axi_rdata = rData_r;
   end

   ////////////////////////////////////////////////////////////////////////////
   // all registers of this module
   // reset leaves the cpu on the low source with divider 000 and no stabilization wait
   always_ff @(posedge clock) begin
      if (reset) begin
         sel_r <= `SEL_RST;
         div_r <= `DIV_RST;
         mainStop_r <= `STOP_RST;
         lowStop_r <= `STOP_RST;
         stabSel_r <= `STABSEL_RST;
         stab_r <= '0;
         stabHold_r <= 1'b0;
         awHeld_r <= 1'b0;
         wHeld_r <= 1'b0;
         awAddr_r <= 32'h0;
         wData_r <= 32'h0;
         wStrb_r <= 4'h0;
         bValid_r <= 1'b0;
         bResp_r <= `RESP_OKAY;
         rValid_r <= 1'b0;
         rResp_r <= `RESP_OKAY;
         rData_r <= 32'h0;
      end else begin
         sel_r <= sel_nxt;
         div_r <= div_nxt;
         mainStop_r <= mainStop_nxt;
         lowStop_r <= lowStop_nxt;
         stabSel_r <= stabSel_nxt;
         stab_r <= stab_nxt;
         stabHold_r <= stabHold_nxt;
         awHeld_r <= awHeld_nxt;
         wHeld_r <= wHeld_nxt;
         awAddr_r <= awAddr_nxt;
         wData_r <= wData_nxt;
         wStrb_r <= wStrb_nxt;
         bValid_r <= bValid_nxt;
         bResp_r <= bResp_nxt;
         rValid_r <= rValid_nxt;
         rResp_r <= rResp_nxt;
         rData_r <= rData_nxt;
      end
   end
endmodule : cpu_clock_source_switcher

// ### verif/cpu_clock_source_switcher_properties.sv
// port-level checker for the cpu clock source switcher
`timescale 1ns/100ps
module cpu_clock_source_switcher_checker (
   input wire logic clock,
   input wire logic reset,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic lowTick,
   input wire logic lowOscStoppable,
   input wire logic stopMode,
   input wire logic cpuTick,
   input wire logic cpuOnHigh,
   input wire logic mainOscEnable,
   input wire logic lowOscEnable
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (reset);
   ////////////////////////////////////////
   // a write whose halves are taken together answers two edges later
   sequence wrTaken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence wrAnswer;
      !s_axi_bvalid ##1 s_axi_bvalid;
   endsequence
   a_write_answer: assert property (wrTaken |=> wrAnswer)
      else $error("write answer not two cycles after acceptance");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer not one cycle after acceptance");
   ////////////////////////////////////////
   // the oscillator that clocks the cpu can never be stopped, nor the low one while the option does not make it stoppable
   a_main_osc_kept: assert property (cpuOnHigh |-> mainOscEnable)
      else $error("main oscillator stopped while clocking the cpu");
   a_low_osc_kept: assert property (!cpuOnHigh |-> lowOscEnable)
      else $error("low oscillator stopped while clocking the cpu");
   a_low_osc_fixed: assert property (!lowOscStoppable |-> lowOscEnable)
      else $error("low oscillator stopped though not stoppable");
   // status flips only at a hand-over edge of the mux
   a_status_up_edge: assert property ($rose(cpuOnHigh) |-> $past(cpuTick))
      else $error("status rose without an old cpu tick");
   a_status_down_edge: assert property ($fell(cpuOnHigh) |-> $past(lowTick))
      else $error("status fell without a low tick");
   // first stop cycle may still carry a tick if the gate is registered
   a_stop_no_tick: assert property (stopMode [*2] |-> !cpuTick)
      else $error("cpu tick during stop");
endmodule : cpu_clock_source_switcher_checker

bind cpu_clock_source_switcher cpu_clock_source_switcher_checker i_chk (.clock, .reset,
   .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .lowTick, .lowOscStoppable, .stopMode,
   .cpuTick, .cpuOnHigh, .mainOscEnable, .lowOscEnable);

// ### verif/test_cpu_clock_source_switcher.sv
// self-checking bench for the cpu clock source switcher
`timescale 1ns/100ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin failCount++; \
   $display("FAIL %s exp %0h got %0h", nm, e, g); end end
module test_cpu_clock_source_switcher;
   logic clock, reset, highTick, lowTick, lowOscStoppable, stopMode, wakeByIrq;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_bready, s_axi_rready;
   logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rd;
   logic [3:0] s_axi_wstrb, tickCnt;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic cpuTick, cpuOnHigh, mainOscEnable, lowOscEnable;
   logic [2:0] cpuDivActive;
   logic [2:0] divSeq [6] = '{3'h0, 3'h4, 3'h3, 3'h2, 3'h1, 3'h0};
   int failCount, compares, n, cyc;

   cpu_clock_source_switcher i_dut (.clock, .reset, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .highTick, .lowTick,
      .lowOscStoppable, .stopMode, .wakeByIrq, .cpuTick, .cpuOnHigh, .mainOscEnable,
      .lowOscEnable, .cpuDivActive);

   ////////////////////////////////////////
   // 200 MHz clock
   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end

   // oscillators at a ratio of 8; a stopped oscillator gives no ticks at all
   always @(posedge clock) begin
      cyc <= cyc + 1;
      tickCnt <= tickCnt + 4'h1;
      highTick <= mainOscEnable && tickCnt[0];
      lowTick <= lowOscEnable && (tickCnt == 4'hf);
   end

   ////////////////////////////////////////
   // bus tasks; bready and rready stay high, so every answer is taken at once
   task automatic axiWrite(input logic [31:0] a, input logic [31:0] d,
      input logic [3:0] s = 4'hf, input logic [1:0] er = 2'h0);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do begin
         @(posedge clock);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      `CHK("write response", er, s_axi_bresp)
   endtask : axiWrite

   task automatic axiRead(input logic [31:0] a);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do begin
         @(posedge clock);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      rd = s_axi_rdata;
   endtask : axiRead

   task automatic rdChk(input logic [31:0] a, input logic [31:0] e, input logic [1:0] er = 2'h0);
      axiRead(a);
      `CHK("read", {er, e}, {s_axi_rresp, rd})
   endtask : rdChk

   // counts old cpu ticks until status and divider reach the wanted pair
   task automatic oldTicks(input logic [3:0] want);
      n = 0;
      do begin
         @(posedge clock);
         if (cpuTick && {cpuOnHigh, cpuDivActive} !== want) n++;
      end while ({cpuOnHigh, cpuDivActive} !== want);
   endtask : oldTicks

   task automatic tickGap();
      do @(posedge clock); while (!cpuTick);
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (!cpuTick);
   endtask : tickGap

   // enters stop, wakes by interrupt and counts cycles to the first cpu tick
   task automatic stopWake();
      stopMode <= 1'b1;
      repeat (40) @(posedge clock);
      wakeByIrq <= 1'b1;
      @(posedge clock);
      wakeByIrq <= 1'b0;
      stopMode <= 1'b0;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (!cpuTick);
   endtask : stopWake

   task automatic endOfTest();
      if (failCount == 0 && compares > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : endOfTest

   ////////////////////////////////////////
   // a hang is cut off well past the roughly 9000 cycles the tests need
   initial begin
      repeat (40000) @(posedge clock);
      failCount++;
      endOfTest();
   end

   // main sequence
   initial begin
      {reset, s_axi_bready, s_axi_rready, s_axi_wstrb} = 7'h7f;
      {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, lowOscStoppable, stopMode, wakeByIrq} = 6'h0;
      {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
      {tickCnt, highTick, lowTick, cyc} = 0;
      repeat (5) @(posedge clock);
      reset <= 1'b0;
      @(posedge clock);
      for (int i = 0; i < 6; i++) begin
         rdChk(i * 4, (i == 5) ? 32'h4 : 32'h0);
      end
      `CHK("idle outputs", 6'h03, {cpuOnHigh, cpuDivActive, mainOscEnable, lowOscEnable})
      rdChk(32'h18, 32'h0, 2'h2);
      axiWrite(32'h18, 32'h1, 4'hf, 2'h2);
      axiWrite(32'h00, 32'h3, 4'he);
      axiWrite(32'h00, 32'h2);
      axiWrite(32'h10, 32'hf);
      rdChk(32'h00, 32'h0);
      // the crystal flow polls the status; an internal fast source waits at the same place
      do axiRead(32'h10); while (rd === 32'h0);
      `CHK("stab first bit", 32'h1, rd)
      `CHK("stab time", 1'b1, cyc > 4090)
      // low to high
      axiWrite(32'h00, 32'h1);
      `CHK("status early", 1'b0, cpuOnHigh)
      oldTicks(4'h8);
      `CHK("to high ticks", 1'b1, n <= 2)
      rdChk(32'h00, 32'h3);
      for (int i = 0; i < 5; i++) begin
         axiWrite(32'h04, {29'h0, divSeq[i + 1]});
         oldTicks({1'b1, divSeq[i + 1]});
         `CHK("divider ticks", 1'b1, n <= (16 >> divSeq[i]))
         tickGap();
         `CHK("cpu period", 2 << divSeq[i + 1], n)
      end
      // stop bits while on the high clock
      axiWrite(32'h08, 32'h80);
      rdChk(32'h08, 32'h80);
      `CHK("main kept", 1'b1, mainOscEnable)
      axiWrite(32'h08, 32'h0);
      axiWrite(32'h0c, 32'h1);
      `CHK("low fixed", 1'b1, lowOscEnable)
      lowOscStoppable <= 1'b1;
      @(posedge clock);
      `CHK("low stopped", 1'b0, lowOscEnable)
      axiWrite(32'h0c, 32'h0);
      axiWrite(32'h14, 32'h0);
      stopWake();
      `CHK("stab wait", 1'b1, n > 4090)
      // high to low
      axiWrite(32'h00, 32'h0);
      oldTicks(4'h0);
      `CHK("to low ticks", 1'b1, n <= 9)
      axiWrite(32'h0c, 32'h1);
      `CHK("low kept", 1'b1, lowOscEnable)
      axiWrite(32'h0c, 32'h0);
      axiWrite(32'h08, 32'h80);
      `CHK("main stopped", 1'b0, mainOscEnable)
      rdChk(32'h00, 32'h0);
      axiWrite(32'h04, 32'h1);
      oldTicks(4'h1);
      `CHK("low divider ticks", 1'b1, n <= 16)
      stopWake();
      `CHK("no stab wait", 1'b1, n <= 40)
      endOfTest();
   end
endmodule : test_cpu_clock_source_switcher
